// ---- design/tt_err_level.sv ----
// Time-triggered error level monitor with reference payload and receive status update
//
// Functional notes
// - S2 blocks data frames, offset forced 127 when time master
// - S3 stops bus, no dominant, monitor
// - S3 holds until config change enable
// - Most severe wins, level changed flag
// - Config error sets level 11
// - Watch trigger reached sets level 11
// - Unserved watchdog: event, flag, 11, monitor
// - Bus-off sets 11, status and init
// - Tx count seven: level 10, flag
// - Tx overflow: level 10, flag
// - Spread or rx count seven: level 01
// - Tx underflow at matrix start: level 01
// - Reference uses configured identifier, entity bytes
// - Buffer 0 payload when selected, pending and longer than entity bytes
// - Reference identifier used for filtering
// - Reception routed to the receive FIFO on filter match
// - Rx count updated at trigger, in sync
// - Match decrements, mismatch increments count
// - Filter result cleared at trigger, cycle start
// - Flags stay set until written one
`timescale 1ns/10ps

module tt_err_level
   import tt_err_pkg::*;
#(
   parameter int AWD_W = 8,  // Width of the watchdog limit
   parameter int TX_CNT_W = 7  // Width of transmit counts
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire tt_err_pkg::sched_ev_s sched_ev,
   input wire tt_err_pkg::tt_level_e tt_level,
   input wire logic time_master,
   input wire logic in_sync,
   input wire logic config_change_enable,
   input wire logic [AWD_W-1:0] app_watchdog_limit,
   input wire logic awd_tick,
   input wire logic status_read,
   input wire logic [TX_CNT_W-1:0] tx_count,
   input wire logic [TX_CNT_W-1:0] expected_tx_trigger_count,
   input wire logic tx_msc_at_limit,
   input wire logic [2:0] excl_msc_max,
   input wire logic [2:0] excl_msc_min,
   input wire tt_err_pkg::rx_elem_s rx_elem,
   input wire logic filter_match,
   input wire logic [6:0] filter_match_num,
   input wire logic [28:0] reference_identifier,
   input wire logic [28:0] rx_identifier,
   input wire logic rx_id_valid,
   input wire logic ref_payload_select,
   input wire logic buf0_request_pending,
   input wire logic [3:0] buf0_dlc,
   input wire logic ref_start,
   input wire tt_err_pkg::tt_flags_s flag_clear,
   output logic [1:0] error_level_field,
   output tt_err_pkg::tt_flags_s irq_flags,
   output logic app_watchdog_event_bit,
   output logic bus_monitor_bit,
   output logic initialization_bit,
   output logic bus_off_status,
   output logic tx_frames_enable,
   output logic dominant_enable,
   output logic [6:0] reference_trigger_offset,
   output logic [28:0] ref_tx_identifier,
   output logic [3:0] ref_fse_bytes,
   output logic [3:0] ref_total_bytes,
   output logic ref_from_buf0,
   output logic ref_id_hit,
   output logic rx_to_fifo,
   output logic msc_write,
   output logic [2:0] msc_new
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (AWD_W < 1 || TX_CNT_W < 1)
   begin : g_bad_width
      $error("tt_err_level: widths must be positive");
   end

   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   logic rst_q1;  // First stage, read only by second
   logic rst_n;  // Internal reset copy

   // Release reset through two flip-flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ----------------------------------------
   // Severe condition sources
   // ----------------------------------------
   logic [AWD_W-1:0] awd_cnt;  // Watchdog ticks since last service
   logic severe_latch;  // Sticky S3 until reconfiguration
   logic awd_expire;
   logic cfg_err;
   logic severe_ev;

   assign awd_expire = awd_tick && !status_read && (awd_cnt >= app_watchdog_limit)
      && (app_watchdog_limit != '0);
   assign cfg_err = sched_ev.merged_unclosed || sched_ev.txmark_beyond_ref;
   assign severe_ev = cfg_err || sched_ev.watch_reached
      || awd_expire || sched_ev.bus_off_entry;

   // Watchdog counter, served by status register reads
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         awd_cnt <= '0;
      else if (status_read || severe_latch)
         awd_cnt <= '0;  // Serviced, or already stopped
      else if (awd_tick && awd_cnt != '1)
         awd_cnt <= awd_cnt + 1'b1;
   end

   // Severe level is held until software opens configuration
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         severe_latch <= 1'b0;
      else if (severe_ev)
         severe_latch <= 1'b1;  // Event wins over the clearing write
      else if (config_change_enable)
         severe_latch <= 1'b0;
   end

   // Watchdog event and bus-off bits set by their own events, monitor bit by any severe event; all clear at reconfiguration
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         app_watchdog_event_bit <= 1'b0;
         bus_off_status <= 1'b0;
         initialization_bit <= 1'b0;
         bus_monitor_bit <= 1'b0;
      end
      else
      begin
         if (awd_expire)
            app_watchdog_event_bit <= 1'b1;
         else if (config_change_enable)
            app_watchdog_event_bit <= 1'b0;
         if (sched_ev.bus_off_entry)
         begin
            bus_off_status <= 1'b1;
            initialization_bit <= 1'b1;
         end
         else if (config_change_enable)
         begin
            bus_off_status <= 1'b0;
            initialization_bit <= 1'b0;
         end
         if (severe_ev)
            bus_monitor_bit <= 1'b1;
         else if (config_change_enable)
            bus_monitor_bit <= 1'b0;
      end
   end

   // ----------------------------------------
   // Error and warning sources
   // ----------------------------------------
   logic err_state;  // S2 condition held to matrix start
   logic warn_state;  // S1 condition held to matrix start
   logic se2_hit_cyc;  // Some tx count reached 7 this matrix cycle
   logic se1_hit_cyc;  // Spread or rx limit seen this matrix cycle
   logic txo_ev;
   logic se2_ev;
   logic se1_ev;
   logic txu_ev;
   logic spread_bad;
   logic rx_limit;

   assign txo_ev = sched_ev.tx_trigger && (tx_count >= expected_tx_trigger_count);
   assign se2_ev = tx_msc_at_limit;
   assign spread_bad = (excl_msc_max - excl_msc_min) > MSC_SPREAD_MAX;
   assign rx_limit = rx_elem.exclusive && (rx_elem.message_status_count == MSC_LIMIT);
   assign se1_ev = spread_bad || rx_limit;
   assign txu_ev = sched_ev.matrix_start
      && (tx_count < expected_tx_trigger_count);

   // Levels 10 and 01 persist through the matrix cycle and are reassessed at its start
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_state <= 1'b0;
         warn_state <= 1'b0;
         se2_hit_cyc <= 1'b0;
         se1_hit_cyc <= 1'b0;
      end
      else if (sched_ev.matrix_start)
      begin
         // Held unless the closing cycle was clean; new events still count
         err_state <= 1'b1;
         warn_state <= 1'b1;
         se2_hit_cyc <= se2_ev;
         se1_hit_cyc <= se1_ev;
         if (!se2_hit_cyc && !se2_ev && !txo_ev && !(tx_count > expected_tx_trigger_count))
            err_state <= 1'b0;
         if (!se1_hit_cyc && !se1_ev && !txu_ev)
            warn_state <= 1'b0;
      end
      else
      begin
         if (se2_ev || txo_ev)
            err_state <= 1'b1;
         if (se1_ev)
            warn_state <= 1'b1;
         se2_hit_cyc <= se2_hit_cyc || se2_ev;
         se1_hit_cyc <= se1_hit_cyc || se1_ev;
      end
   end

   // ----------------------------------------
   // Level selection, most severe prevails
   // ----------------------------------------
   logic [1:0] next_level;
   assign next_level = ((severe_latch && !config_change_enable) || severe_ev)
      ? LVL_SEVERE : err_state ? LVL_ERR :
      warn_state ? LVL_WARN : LVL_NONE;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         error_level_field <= RST_LEVEL;
      else
         error_level_field <= next_level;
   end

   // ----------------------------------------
   // Sticky flags, write one to clear
   // ----------------------------------------
   tt_flags_s flag_set;
   assign flag_set.elc = severe_ev || se2_ev || txo_ev || se1_ev || txu_ev;
   assign flag_set.se1 = se1_ev;
   assign flag_set.se2 = se2_ev;
   assign flag_set.txo = txo_ev;
   assign flag_set.txu = txu_ev;
   assign flag_set.aw = awd_expire;

   // Set beats a same-cycle clear so no event is lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_flags <= '0;
      else
         irq_flags <= flag_set | (irq_flags & ~flag_clear);
   end

   // ----------------------------------------
   // Bus gating by level
   // ----------------------------------------
   // Registered from the next level so outputs stay flop driven and change in the same cycle as the level field
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_frames_enable <= 1'b1;
         dominant_enable <= 1'b1;
         reference_trigger_offset <= '0;
      end
      else
      begin
         tx_frames_enable <= (next_level == LVL_NONE) || (next_level == LVL_WARN);
         dominant_enable <= (next_level != LVL_SEVERE);
         reference_trigger_offset <= (next_level == LVL_ERR && time_master)
            ? RTO_MAX : '0;
      end
   end

   // ----------------------------------------
   // Reference message assembly
   // ----------------------------------------
   logic [3:0] fse_bytes;
   logic use_buf0;
   logic [3:0] buf0_len;
   assign fse_bytes = (tt_level == TT_LEVEL1) ? 4'(FSE_BYTES_L1) : 4'(FSE_BYTES_L02);
   assign use_buf0 = ref_payload_select && buf0_request_pending;
   assign buf0_len = (buf0_dlc > DLC_MAX8) ? DLC_MAX8 : buf0_dlc;

   // Captured at reference start so later buffer edits cannot tear the frame
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_tx_identifier <= '0;
         ref_fse_bytes <= '0;
         ref_total_bytes <= '0;
         ref_from_buf0 <= 1'b0;
      end
      else if (ref_start && time_master)
      begin
         ref_tx_identifier <= reference_identifier;
         ref_fse_bytes <= fse_bytes;
         ref_from_buf0 <= use_buf0 && (buf0_len > fse_bytes);
         ref_total_bytes <= (use_buf0 && buf0_len > fse_bytes) ? buf0_len : fse_bytes;
      end
   end

   // Identifier recognition and FIFO routing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_id_hit <= 1'b0;
         rx_to_fifo <= 1'b0;
      end
      else
      begin
         ref_id_hit <= rx_id_valid && (rx_identifier == reference_identifier);
         rx_to_fifo <= filter_match;
      end
   end

   // ----------------------------------------
   // Receive trigger status count update
   // ----------------------------------------
   logic afr_valid;  // Stored filter result present
   logic [6:0] afr_num;  // Stored filter number
   logic rx_hit;
   assign rx_hit = afr_valid && (afr_num == rx_elem.filter_num);

   // Latest match of the basic cycle, cleared at receive triggers and cycle starts
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         afr_valid <= 1'b0;
         afr_num <= '0;
      end
      else if (sched_ev.rx_trigger || sched_ev.cycle_start)
         afr_valid <= 1'b0;
      else if (filter_match)
      begin
         afr_valid <= 1'b1;
         afr_num <= filter_match_num;
      end
   end

   // Saturating count update; counts start at zero by software setup
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msc_write <= 1'b0;
         msc_new <= '0;
      end
      else
      begin
         msc_write <= sched_ev.rx_trigger && in_sync;
         if (rx_hit)
            msc_new <= (rx_elem.message_status_count == '0) ? '0 : rx_elem.message_status_count - 1'b1;
         else
            msc_new <= (rx_elem.message_status_count == MSC_LIMIT) ? MSC_LIMIT : rx_elem.message_status_count + 1'b1;
      end
   end

endmodule : tt_err_level

// ---- include/tt_err_pkg.sv ----
// Package with constants and carrier types for the time-triggered error level monitor
package tt_err_pkg;

   // ----------------------------------------
   // Error level encoding
   // ----------------------------------------
   localparam logic [1:0] LVL_NONE = 2'h0;  // No error
   localparam logic [1:0] LVL_WARN = 2'h1;  // Warning
   localparam logic [1:0] LVL_ERR = 2'h2;  // Error
   localparam logic [1:0] LVL_SEVERE = 2'h3;  // Severe error

   // ----------------------------------------
   // Counts and limits
   // ----------------------------------------
   localparam int MSC_W = 3;  // Status count width
   localparam logic [2:0] MSC_LIMIT = 3'h7;  // Count that marks a scheduling fault
   localparam logic [2:0] MSC_SPREAD_MAX = 3'h2;  // Largest tolerated max-min spread
   localparam logic [6:0] RTO_MAX = 7'h7f;  // Reference trigger offset forced at S2
   localparam int FSE_BYTES_L1 = 1;  // Entity bytes in level 1
   localparam int FSE_BYTES_L02 = 4;  // Entity bytes in levels 0 and 2
   localparam logic [3:0] DLC_MAX8 = 4'h8;  // Classic frame payload cap
   localparam logic [1:0] RST_LEVEL = 2'h0;  // Error level after reset

   // ----------------------------------------
   // Time-triggered level of operation
   // ----------------------------------------
   typedef enum logic [1:0] {TT_LEVEL0, TT_LEVEL1, TT_LEVEL2} tt_level_e;

   // Events from the trigger scheduler in one cycle
   typedef struct packed {
      logic cycle_start;  // Basic cycle start
      logic matrix_start;  // Matrix cycle start
      logic tx_trigger;  // A transmit trigger fired
      logic rx_trigger;  // A receive trigger fired
      logic watch_reached;  // Watch trigger reached, no reference seen
      logic merged_unclosed;  // Merged window left open
      logic txmark_beyond_ref;  // Transmit mark past reference trigger
      logic bus_off_entry;  // Controller entering bus-off
   } sched_ev_s;

   // Receive trigger element being processed
   typedef struct packed {
      logic [6:0] filter_num;  // Filter number of the element
      logic [2:0] message_status_count;  // Current status count
      logic exclusive;  // Element belongs to an exclusive window
   } rx_elem_s;

   // Interrupt flag bits, also used for their set and clear pulses
   typedef struct packed {
      logic elc;
      logic se1;
      logic se2;
      logic txo;
      logic txu;
      logic aw;
   } tt_flags_s;

endpackage : tt_err_pkg

// ---- verification/tt_err_level_monitor.sv ----
// Port checker for the error level monitor
`timescale 1ns/10ps
module tt_err_level_monitor
   import tt_err_pkg::*;
#(
   parameter int AWD_W = 8,
   parameter int TX_CNT_W = 7
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire tt_err_pkg::sched_ev_s sched_ev,
   input wire logic in_sync,
   input wire logic config_change_enable,
   input wire logic [TX_CNT_W-1:0] tx_count,
   input wire logic [TX_CNT_W-1:0] expected_tx_trigger_count,
   input wire logic [28:0] reference_identifier,
   input wire logic [28:0] rx_identifier,
   input wire logic rx_id_valid,
   input wire tt_err_pkg::tt_flags_s flag_clear,
   input wire logic [1:0] error_level_field,
   input wire tt_err_pkg::tt_flags_s irq_flags,
   input wire logic bus_monitor_bit,
   input wire logic initialization_bit,
   input wire logic bus_off_status,
   input wire logic tx_frames_enable,
   input wire logic dominant_enable,
   input wire logic ref_id_hit,
   input wire logic msc_write
);
   // The pin reset masks checks; the lagging internal copy keeps outputs idle
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Severe level together with its notification
   sequence s_severe;
      error_level_field == LVL_SEVERE && irq_flags.elc;
   endsequence
   AST_WATCH: assert property (sched_ev.watch_reached |=> s_severe)
      else $error("watch trigger missed severe level");
   AST_CONFIG: assert property ((sched_ev.merged_unclosed || sched_ev.txmark_beyond_ref)
      |=> s_severe) else $error("config fault missed severe level");
   AST_BUSOFF: assert property (sched_ev.bus_off_entry
      |=> s_severe ##0 (bus_off_status && initialization_bit)) else $error("bus-off state wrong");
   AST_S3_GATE: assert property (error_level_field == LVL_SEVERE
      |-> bus_monitor_bit && !dominant_enable && !tx_frames_enable) else $error("bus not stopped");
   AST_S3_HOLD: assert property (error_level_field == LVL_SEVERE && !config_change_enable
      |=> error_level_field == LVL_SEVERE) else $error("severe level left early");
   AST_S2_GATE: assert property (error_level_field == LVL_ERR |-> !tx_frames_enable)
      else $error("data frames allowed at error level");
   AST_TXO: assert property (sched_ev.tx_trigger && tx_count >= expected_tx_trigger_count
      |=> irq_flags.txo) else $error("overflow flag missing");
   AST_MSC: assert property (sched_ev.rx_trigger |=> msc_write == $past(in_sync))
      else $error("status count update wrong");
   AST_STICKY: assert property (irq_flags.elc && !flag_clear.elc |=> irq_flags.elc)
      else $error("level flag dropped");
   AST_REF_HIT: assert property (rx_id_valid && rx_identifier == reference_identifier
      |=> ref_id_hit) else $error("reference not recognised");
endmodule : tt_err_level_monitor
bind tt_err_level tt_err_level_monitor #(.AWD_W(AWD_W), .TX_CNT_W(TX_CNT_W)) u_monitor (
   .clk, .resetn, .sched_ev, .in_sync, .config_change_enable, .tx_count,
   .expected_tx_trigger_count, .reference_identifier, .rx_identifier, .rx_id_valid,
   .flag_clear, .error_level_field, .irq_flags, .bus_monitor_bit, .initialization_bit,
   .bus_off_status, .tx_frames_enable, .dominant_enable, .ref_id_hit, .msc_write);

// ---- verification/tt_node_model.sv ----
// Model of another bus node whose frames reach acceptance filtering
`timescale 1ns/10ps
module tt_node_model (
   input wire logic clk,
   input wire logic send,
   input wire logic [28:0] send_id,
   input wire logic [6:0] send_filter,
   output logic [28:0] rx_identifier = 29'h0,
   output logic rx_id_valid = 1'b0,
   output logic filter_match = 1'b0,
   output logic [6:0] filter_match_num = 7'h0
);
   // A frame lasts one cycle; outside it the lines toggle so stale data never looks fresh
   always @(posedge clk)
   begin
      rx_id_valid <= send;
      filter_match <= send;
      rx_identifier <= send ? send_id : ~rx_identifier;
      filter_match_num <= send ? send_filter : ~filter_match_num;
   end
endmodule : tt_node_model

// ---- verification/test_tt_err_level.sv ----
// Self-checking bench for the error level monitor
`timescale 1ns/10ps
`define CHK(g, e, m) check((g) === (e), m)
module test_tt_err_level;
   import tt_err_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, tm = 1'b0, sync = 1'b0, cce = 1'b0;
   logic tick = 1'b0, srd = 1'b0, msc7 = 1'b0, sel = 1'b0, pend = 1'b0, rstart = 1'b0;
   logic send = 1'b0, rxv, fm, awe, mon, init, boff, txen, domen, hit, fifo, mw, from0;
   sched_ev_s ev = '0;
   tt_level_e lvl = TT_LEVEL1;
   logic [7:0] awl = 8'h0;
   logic [6:0] txc = 7'h4, ent = 7'h4, sfilt = 7'h0, fmn, rto;
   logic [2:0] mx = 3'h0, mn = 3'h0, mnew;
   rx_elem_s elem = '0;
   logic [28:0] rid = 29'h0a5, sid = 29'h0, rxid, ref_id;
   logic [3:0] dlc = 4'h8, fse_n, tot_n;
   tt_flags_s fclr = '0, fl;
   logic [1:0] el;
   int n_errors = 0, tests_run = 0, cycles = 0;
   tt_node_model node (.clk, .send, .send_id(sid), .send_filter(sfilt), .rx_identifier(rxid),
      .rx_id_valid(rxv), .filter_match(fm), .filter_match_num(fmn));
   tt_err_level dut (.clk, .resetn, .sched_ev(ev), .tt_level(lvl), .time_master(tm),
      .in_sync(sync), .config_change_enable(cce), .app_watchdog_limit(awl), .awd_tick(tick),
      .status_read(srd), .tx_count(txc), .expected_tx_trigger_count(ent),
      .tx_msc_at_limit(msc7), .excl_msc_max(mx), .excl_msc_min(mn), .rx_elem(elem),
      .filter_match(fm), .filter_match_num(fmn), .reference_identifier(rid),
      .rx_identifier(rxid), .rx_id_valid(rxv), .ref_payload_select(sel),
      .buf0_request_pending(pend), .buf0_dlc(dlc), .ref_start(rstart), .flag_clear(fclr),
      .error_level_field(el), .irq_flags(fl), .app_watchdog_event_bit(awe),
      .bus_monitor_bit(mon), .initialization_bit(init), .bus_off_status(boff),
      .tx_frames_enable(txen), .dominant_enable(domen), .reference_trigger_offset(rto),
      .ref_tx_identifier(ref_id), .ref_fse_bytes(fse_n), .ref_total_bytes(tot_n),
      .ref_from_buf0(from0), .ref_id_hit(hit), .rx_to_fifo(fifo), .msc_write(mw),
      .msc_new(mnew));
   initial
   begin
      forever #5 clk = ~clk;
   end
   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_errors++;
         conclude();
      end
   end
   task check(input bit ok, input string m);
      tests_run++;
      if (!ok)
      begin
         n_errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : check
   task conclude;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // One-cycle scheduler event; result judged at the following falling edge
   task pulse(input logic [7:0] b);
      @(posedge clk);
      ev <= sched_ev_s'(b);
      @(posedge clk);
      ev <= '0;
      @(negedge clk);
   endtask : pulse
   task mstart(input int n);
      repeat (n) pulse(8'h40);
      @(negedge clk);  // Reassessed level shows one edge after the matrix start
   endtask : mstart
   // Host reconfigures and clears every flag at once
   task reconfig;
      @(posedge clk);
      cce <= 1'b1;
      fclr <= '1;
      @(posedge clk);
      cce <= 1'b0;
      fclr <= '0;
      @(negedge clk);
      `CHK({el inside {LVL_NONE, LVL_WARN, LVL_ERR}, boff, init, fl}, 9'h100, "not left");
   endtask : reconfig
   task t_severe;
      static logic [7:0] src [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
      foreach (src[i])
      begin
         pulse(src[i]);
         `CHK({el, fl.elc, mon, domen, txen}, {LVL_SEVERE, 4'b1100}, "severe");
         if (i == 3)
            `CHK({boff, init}, 2'b11, "bus-off bits");
         repeat (3) @(posedge clk);
         @(negedge clk);
         `CHK({el, fl.elc}, {LVL_SEVERE, 1'b1}, "severe not held");
         reconfig();
      end
   endtask : t_severe
   task t_s2;
      @(posedge clk);
      tm <= 1'b1;
      pulse(8'h20);
      @(negedge clk);
      `CHK({el, fl.txo, txen}, {LVL_ERR, 2'b10}, "overflow");
      `CHK(rto, RTO_MAX, "offset at error level");
      mstart(2);
      `CHK(el, LVL_NONE, "overflow kept");
      @(posedge clk);
      txc <= 7'h3;
      mstart(1);
      `CHK({el, fl.txu}, {LVL_WARN, 1'b1}, "underflow");
      @(posedge clk);
      txc <= 7'h4;
      mstart(1);
      `CHK(el, LVL_NONE, "underflow kept");
      @(posedge clk);
      msc7 <= 1'b1;
      @(posedge clk);
      msc7 <= 1'b0;
      @(negedge clk);
      @(negedge clk);
      `CHK({el, fl.se2}, {LVL_ERR, 1'b1}, "count seven");
      mstart(1);
      `CHK(el, LVL_ERR, "count seven dropped early");
      mstart(1);
      `CHK(el, LVL_NONE, "count seven kept");
      @(posedge clk);
      msc7 <= 1'b1;
      ev <= sched_ev_s'(8'h08);
      @(posedge clk);
      msc7 <= 1'b0;
      ev <= '0;
      @(negedge clk);
      `CHK(el, LVL_SEVERE, "severity order");
      reconfig();
      mstart(2);
   endtask : t_s2
   // Spread of exactly two is tolerated, three is not
   task t_se1;
      @(posedge clk);
      mx <= 3'h4;
      mn <= 3'h2;
      mstart(2);
      `CHK({el, fl.se1}, {LVL_NONE, 1'b0}, "spread two");
      @(posedge clk);
      mx <= 3'h5;
      mstart(1);
      `CHK({el, fl.se1}, {LVL_WARN, 1'b1}, "spread three");
      @(posedge clk);
      mx <= 3'h2;
      mstart(2);
      `CHK(el, LVL_NONE, "spread kept");
   endtask : t_se1
   task t_ref;
      logic [3:0] n;
      for (int l = 0; l < 3; l++)
         for (int s = 0; s < 4; s++)
         begin
            @(posedge clk);
            lvl <= tt_level_e'(l);
            {sel, pend} <= s[1:0];
            rstart <= 1'b1;
            @(posedge clk);
            rstart <= 1'b0;
            @(negedge clk);
            n = (l == 1) ? 4'h1 : 4'h4;
            `CHK({ref_id, fse_n, tot_n, from0}, {rid, n, (s == 3) ? 4'h8 : n, s == 3}, "ref");
         end
   endtask : t_ref
   // Frame well ahead of the receive trigger
   task frame(input logic [28:0] id, input logic [6:0] f);
      @(posedge clk);
      sid <= id;
      sfilt <= f;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK({fifo, hit}, {1'b1, id == rid}, "frame delivery");
   endtask : frame
   task rxtrig(input logic [2:0] m, input logic [6:0] f, input logic s, input logic [2:0] e);
      @(posedge clk);
      elem <= '{f, m, 1'b1};
      sync <= s;
      pulse(8'h10);
      `CHK({mw, s ? mnew : 3'h0}, {s, s ? e : 3'h0}, "status count");
   endtask : rxtrig
   task t_rx;
      frame(29'h123, 7'h05);
      rxtrig(3'h0, 7'h05, 1'b1, 3'h0);
      rxtrig(3'h0, 7'h05, 1'b1, 3'h1);
      frame(29'h124, 7'h06);
      rxtrig(3'h3, 7'h05, 1'b1, 3'h4);
      frame(rid, 7'h05);
      pulse(8'h80);
      rxtrig(3'h3, 7'h05, 1'b1, 3'h4);
      frame(29'h125, 7'h05);
      rxtrig(3'h3, 7'h05, 1'b1, 3'h2);
      rxtrig(3'h7, 7'h06, 1'b1, 3'h7);
      rxtrig(3'h3, 7'h05, 1'b0, 3'h0);
   endtask : t_rx
   // Four watchdog ticks, served or not
   task wd(input logic serve);
      @(posedge clk);
      awl <= 8'h02;
      repeat (4)
      begin
         @(posedge clk);
         tick <= 1'b1;
         srd <= serve;
         @(posedge clk);
         tick <= 1'b0;
         srd <= 1'b0;
      end
      @(posedge clk);
      @(negedge clk);
      `CHK({fl.aw, awe, el == LVL_SEVERE, mon}, {4{~serve}}, "watchdog");
      @(posedge clk);
      awl <= 8'h0;
      reconfig();
   endtask : wd
   initial
   begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK({el, txen, domen, mon}, {LVL_NONE, 3'b110}, "reset state");
      t_severe();
      t_s2();
      t_se1();
      t_ref();
      t_rx();
      wd(1'b1);
      wd(1'b0);
      conclude();
   end
endmodule : test_tt_err_level
